// File: cdp_datapath.sv
// data-processing datapath: arithmetic, multiply, byte, field, clamp, divide
// Operation
// - the second operand is the register value or the immediate for add, subtract, logic and move; multiplies, clamps and divides take the register.
// - result and flags are committed only when the condition code passes on the current flags.
// - multiply-accumulate writes the low 32 bits of a*b+c and keeps the flags.
// - multiply-subtract writes c-a*b as 32 bits and keeps the flags.
// - signed long multiply writes the 64-bit product to the low and high results, no flags.
// - signed long accumulate adds the signed product to the 64-bit pair and writes it back.
// - unsigned long accumulate adds the unsigned product to the pair, flags kept.
// - word byte reverse reverses the four bytes.
// - halfword byte swap swaps the bytes inside each half independently.
// - low half swap swaps the low two bytes and sign-extends to 32 bits.
// - field insert, clear and signed/unsigned extract work on an lsb and a width.
// - the special-register write loads the negative, zero, carry and overflow flags.
// - clamps optionally shift, clamp to n bits and set the sticky saturation flag on clamping.
`timescale 1ns/100ps
module cdp_datapath
  import cdp_pkg::*;
(
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_SRST,
  // decoded operation
  input  wire logic        I_OP_VALID,
  input  wire logic [4:0]  I_OP,
  input  wire logic [3:0]  I_COND,
  input  wire logic        I_SET_FLAGS,
  input  wire logic        I_USE_IMM,
  input  wire logic [31:0] I_IMM,
  // register operands
  input  wire logic [31:0] I_RN,
  input  wire logic [31:0] I_RM,
  input  wire logic [31:0] I_RA,
  input  wire logic [31:0] I_DST_OLD,
  input  wire logic [31:0] I_ACC_LO,
  input  wire logic [31:0] I_ACC_HI,
  // field and clamp controls
  input  wire logic [4:0]  I_LSB,
  input  wire logic [5:0]  I_WIDTH,
  input  wire logic [5:0]  I_SAT_N,
  input  wire logic [4:0]  I_SHIFT,
  input  wire logic        I_SHIFT_ASR,
  // results
  output logic             O_BUSY,
  output logic             O_RES_VALID,
  output logic             O_RES_WR,
  output logic             O_WR_HI,
  output logic [31:0]      O_RES_LO,
  output logic [31:0]      O_RES_HI,
  output logic [3:0]       O_FLAGS,
  output logic             O_Q
);

  typedef struct packed {
    logic        busy;
    logic        valid;
    logic        wr;
    logic        wr_hi;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [3:0]  flags;
    logic        q;
  } cdp_st_t;

  localparam cdp_st_t ST_RST = '{busy: 1'b0, valid: 1'b0, wr: 1'b0, wr_hi: 1'b0,
                                 lo: '0, hi: '0, flags: FLAGS_RST, q: QFLAG_RST};

  cdp_st_t            st_r;
  cdp_st_t            st_nxt;
  cdp_op_t            op;
  cdp_div_if          dvi ();
  logic               take;
  logic               cpass;
  logic [31:0]        opb;
  logic [31:0]        badd;
  logic               cin;
  logic [32:0]        sum;
  logic [63:0]        prod_u;
  logic [63:0]        prod_s;
  logic [63:0]        fmask64;
  logic [31:0]        fmask;
  logic [31:0]        shl;
  logic signed [63:0] sv;
  logic signed [63:0] lim;
  logic               fn;
  logic               fz;
  logic               fc;
  logic               fv;

  assign op    = cdp_op_t'(I_OP);
  assign take  = I_OP_VALID && !st_r.busy;
  assign opb   = I_USE_IMM ? I_IMM : I_RM;

  ////////////////////////////////////////////////////////////////////////
  // condition check against the flags currently held
  always_comb begin
    fn = st_r.flags[FLG_N];
    fz = st_r.flags[FLG_Z];
    fc = st_r.flags[FLG_C];
    fv = st_r.flags[FLG_V];
    unique case (cdp_cond_t'(I_COND))
      CC_EQ: cpass = fz;
      CC_NE: cpass = !fz;
      CC_CS: cpass = fc;
      CC_CC: cpass = !fc;
      CC_MI: cpass = fn;
      CC_PL: cpass = !fn;
      CC_VS: cpass = fv;
      CC_VC: cpass = !fv;
      CC_HI: cpass = fc && !fz;
      CC_LS: cpass = !fc || fz;
      CC_GE: cpass = (fn == fv);
      CC_LT: cpass = (fn != fv);
      CC_GT: cpass = !fz && (fn == fv);
      CC_LE: cpass = fz || (fn != fv);
      CC_AL: cpass = 1'b1;
      CC_NV: cpass = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // shared adder, multipliers, field mask and clamp shifter
  always_comb begin
    badd = ((op == OP_SUB) || (op == OP_SUB_CARRY)) ? ~opb : opb;
    unique case (op)
      OP_SUB:                    cin = 1'b1;
      OP_ADD_CARRY, OP_SUB_CARRY: cin = st_r.flags[FLG_C];
      default:                   cin = 1'b0;
    endcase
    sum     = {1'b0, I_RN} + {1'b0, badd} + {32'h0, cin};
    prod_u  = {32'h0, I_RN} * {32'h0, I_RM};
    prod_s  = {{32{I_RN[31]}}, I_RN} * {{32{I_RM[31]}}, I_RM};
    fmask64 = (64'h1 << I_WIDTH) - 64'h1;
    fmask   = 32'(fmask64 << I_LSB);
    shl     = I_SHIFT_ASR ? 32'($signed(I_RM) >>> I_SHIFT) : 32'(I_RM << I_SHIFT);
    sv      = {{32{shl[31]}}, shl};
    lim     = (op == OP_CLAMP_S) ? (64'sh1 <<< (I_SAT_N - 6'h01)) : (64'sh1 <<< I_SAT_N);
  end

  ////////////////////////////////////////////////////////////////////////
  // divider launch; the decoder waits on busy while a divide runs
  assign dvi.start    = take && cpass && ((op == OP_DIV_S) || (op == OP_DIV_U));
  assign dvi.sgn      = (op == OP_DIV_S);
  assign dvi.dividend = I_RN;
  assign dvi.divisor  = I_RM;

  cdp_divider u_div (
    .I_CORE_CLK (I_CORE_CLK),
    .I_SRST     (I_SRST),
    .dv         (dvi)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state: one result per accepted operation
  always_comb begin
    st_nxt       = st_r;
    st_nxt.valid = 1'b0;
    st_nxt.wr    = 1'b0;
    st_nxt.wr_hi = 1'b0;
    if (st_r.busy) begin
      if (dvi.done) begin
        st_nxt.busy  = 1'b0;
        st_nxt.valid = 1'b1;
        st_nxt.wr    = 1'b1;
        st_nxt.lo    = dvi.quotient;
      end
    end else if (take && !cpass) begin
      st_nxt.valid = 1'b1; // failed condition: answered, nothing committed
    end else if (take) begin
      st_nxt.valid = 1'b1;
      st_nxt.wr    = 1'b1;
      unique case (op)
        OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_CARRY: begin
          st_nxt.lo = sum[31:0];
          if (I_SET_FLAGS) begin
            st_nxt.flags = {sum[31], sum[31:0] == '0, sum[32],
                            (I_RN[31] == badd[31]) && (sum[31] != I_RN[31])};
          end
        end
        OP_AND, OP_ORR, OP_EOR, OP_BITCLR, OP_MOVE, OP_MOVE_NOT, OP_MUL: begin
          unique case (op)
            OP_AND:    st_nxt.lo = I_RN & opb;
            OP_ORR:    st_nxt.lo = I_RN | opb;
            OP_EOR:    st_nxt.lo = I_RN ^ opb;
            OP_BITCLR: st_nxt.lo = I_RN & ~opb;
            OP_MOVE:   st_nxt.lo = opb;
            OP_MOVE_NOT: st_nxt.lo = ~opb;
            default:   st_nxt.lo = prod_u[31:0];
          endcase
          // carry and overflow kept: no shifter carry-out in this datapath
          if (I_SET_FLAGS) begin
            st_nxt.flags[FLG_N] = st_nxt.lo[31];
            st_nxt.flags[FLG_Z] = (st_nxt.lo == '0);
          end
        end
        OP_MUL_ACC:      st_nxt.lo = prod_u[31:0] + I_RA;
        OP_MUL_SUBTRACT: st_nxt.lo = I_RA - prod_u[31:0];
        OP_SLONG_MUL, OP_ULONG_MUL, OP_SLONG_ACC, OP_ULONG_ACC: begin
          st_nxt.wr_hi = 1'b1;
          unique case (op)
            OP_SLONG_MUL: {st_nxt.hi, st_nxt.lo} = prod_s;
            OP_ULONG_MUL: {st_nxt.hi, st_nxt.lo} = prod_u;
            OP_SLONG_ACC: {st_nxt.hi, st_nxt.lo} = prod_s + {I_ACC_HI, I_ACC_LO};
            default:      {st_nxt.hi, st_nxt.lo} = prod_u + {I_ACC_HI, I_ACC_LO};
          endcase
        end
        OP_BSWAP_WORD:   st_nxt.lo = {I_RN[7:0], I_RN[15:8], I_RN[23:16], I_RN[31:24]};
        OP_BSWAP_HALVES: st_nxt.lo = {I_RN[23:16], I_RN[31:24], I_RN[7:0], I_RN[15:8]};
        OP_BSWAP_LOSEXT: st_nxt.lo = {{16{I_RN[7]}}, I_RN[7:0], I_RN[15:8]};
        OP_FIELD_INSERT: st_nxt.lo = (I_DST_OLD & ~fmask) | (32'(I_RN << I_LSB) & fmask);
        OP_FIELD_CLEAR:  st_nxt.lo = I_DST_OLD & ~fmask;
        OP_FIELD_ZEXT:   st_nxt.lo = (I_RN >> I_LSB) & fmask64[31:0];
        OP_FIELD_SEXT: begin
          st_nxt.lo = 32'($signed(32'(I_RN << (6'h20 - {1'b0, I_LSB} - I_WIDTH)))
                          >>> (6'h20 - I_WIDTH));
        end
        OP_WRITE_PSR: begin
          st_nxt.wr    = 1'b0;
          st_nxt.flags = I_RN[PSR_NZCV_LO +: 4];
          st_nxt.q     = I_RN[PSR_Q_BIT];
        end
        OP_CLAMP_S, OP_CLAMP_U: begin
          st_nxt.lo = shl;
          if (sv > lim - 64'sh1) begin
            st_nxt.lo = 32'(lim - 64'sh1);
            st_nxt.q  = 1'b1;
          end else if ((op == OP_CLAMP_S) ? (sv < -lim) : (sv < 64'sh0)) begin
            st_nxt.lo = (op == OP_CLAMP_S) ? 32'(-lim) : '0;
            st_nxt.q  = 1'b1;
          end
        end
        OP_DIV_S, OP_DIV_U: begin
          st_nxt.valid = 1'b0;
          st_nxt.wr    = 1'b0;
          st_nxt.busy  = 1'b1;
        end
        default: st_nxt.wr = 1'b0; // undefined code: answered, nothing written
      endcase
    end
  end

  // state register
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_BUSY      = st_r.busy;
  assign O_RES_VALID = st_r.valid;
  assign O_RES_WR    = st_r.wr;
  assign O_WR_HI     = st_r.wr_hi;
  assign O_RES_LO    = st_r.lo;
  assign O_RES_HI    = st_r.hi;
  assign O_FLAGS     = st_r.flags;
  assign O_Q         = st_r.q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  sequence s_go(cdp_op_t o);
    take && cpass && (op == o);
  endsequence

  sequence s_div_go;
    take && cpass && ((op == OP_DIV_S) || (op == OP_DIV_U));
  endsequence

  a_cond_fail_block: assert property (take && !cpass |=> O_RES_VALID && !O_RES_WR && $stable(O_FLAGS))
    else $error("failed condition still committed");
  a_imm_add_sel: assert property (s_go(OP_ADD) ##0 I_USE_IMM |=> O_RES_LO == 32'($past(I_RN) + $past(I_IMM)))
    else $error("immediate operand not used");
  a_mac_low_word: assert property (s_go(OP_MUL_ACC) |=> O_RES_LO == 32'($past(I_RN) * $past(I_RM) + $past(I_RA))
                                   && $stable(O_FLAGS))
    else $error("multiply-accumulate wrong");
  a_mls_low_word: assert property (s_go(OP_MUL_SUBTRACT) |=> O_RES_LO == 32'($past(I_RA) - $past(I_RN) * $past(I_RM)))
    else $error("multiply-subtract wrong");
  a_slong_pair: assert property (s_go(OP_SLONG_MUL) |=> O_WR_HI &&
                                 $signed({O_RES_HI, O_RES_LO}) == $signed($past(I_RN)) * $signed($past(I_RM)))
    else $error("signed long product wrong");
  a_ulong_acc: assert property (s_go(OP_ULONG_ACC) |=> {O_RES_HI, O_RES_LO} ==
                                64'({32'h0, $past(I_RN)} * {32'h0, $past(I_RM)} + {$past(I_ACC_HI), $past(I_ACC_LO)})
                                && $stable(O_FLAGS))
    else $error("unsigned long accumulate wrong");
  a_bswap_word: assert property (s_go(OP_BSWAP_WORD) |=> O_RES_LO == {<<8{$past(I_RN)}})
    else $error("word byte reverse wrong");
  a_psr_flags: assert property (s_go(OP_WRITE_PSR) |=> O_FLAGS == $past(I_RN[31:28]) && !O_RES_WR)
    else $error("flag write wrong");
  a_q_sticky: assert property ($fell(O_Q) |-> $past(take && cpass && op == OP_WRITE_PSR))
    else $error("saturation flag dropped");
  a_div_latency: assert property (s_div_go |=> O_BUSY [*8] ##26 (O_RES_VALID && O_RES_WR && !O_BUSY)
                                  ##0 $stable(O_FLAGS))
    else $error("divide result late or flags moved");

endmodule : cdp_datapath

// File: cdp_datapath_tb.sv
// self-checking bench for the data-processing datapath
`timescale 1ns/100ps
module cdp_datapath_tb
  import cdp_pkg::*, cdp_tb_pkg::*;
;
  logic        clk;
  logic        srst;
  cdp_req_t    req;
  logic        busy, rvalid, rwr, rwr_hi, q;
  logic [31:0] res_lo, res_hi;
  logic [3:0]  flags;
  int          failures;
  int          compares;

  ////////////////////////////////////////////////////////////////////////////
  // design and its far-side stand-in
  cdp_datapath dut (
    .I_CORE_CLK (clk),        .I_SRST     (srst),       .I_OP_VALID (req.valid),
    .I_OP       (req.op),     .I_COND     (req.cond),   .I_SET_FLAGS(req.sf),
    .I_USE_IMM  (req.use_imm),.I_IMM      (req.imm),    .I_RN       (req.rn),
    .I_RM       (req.rm),     .I_RA       (req.ra),     .I_DST_OLD  (req.dst),
    .I_ACC_LO   (req.acc_lo), .I_ACC_HI   (req.acc_hi), .I_LSB      (req.lsb),
    .I_WIDTH    (req.width),  .I_SAT_N    (req.sat_n),  .I_SHIFT    (req.shift),
    .I_SHIFT_ASR(req.asr),    .O_BUSY     (busy),       .O_RES_VALID(rvalid),
    .O_RES_WR   (rwr),        .O_WR_HI    (rwr_hi),     .O_RES_LO   (res_lo),
    .O_RES_HI   (res_hi),     .O_FLAGS    (flags),      .O_Q        (q)
  );
  cdp_dec_model mdl (.i_clk(clk), .i_res_valid(rvalid), .o_req(req));

  // 100 MHz core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  function automatic cdp_req_t mk(input cdp_op_t op, input logic sf, input logic [31:0] rn, rm, ra);
    mk = '0;
    mk.op = op;
    mk.cond = CC_AL;
    mk.sf = sf;
    mk.rn = rn;
    mk.rm = rm;
    mk.ra = ra;
  endfunction : mk

  // condition outcome on {N,Z,C,V}; both top codes always pass
  function automatic logic cpass(input logic [3:0] c, input logic [3:0] f);
    case (c[3:1])
      3'd0: cpass = f[2];
      3'd1: cpass = f[1];
      3'd2: cpass = f[3];
      3'd3: cpass = f[0];
      3'd4: cpass = f[1] & ~f[2];
      3'd5: cpass = f[3] == f[0];
      3'd6: cpass = ~f[2] & (f[3] == f[0]);
      default: cpass = 1'b1;
    endcase
    if (c[0] && c[3:1] != 3'd7)
      cpass = ~cpass;
  endfunction : cpass

  // one op; a latency mismatch past the bound ends the run
  task automatic run(input cdp_req_t r, input int lat);
    int n;
    mdl.issue(r, n);
    check(64'(n), 64'(lat), "answer latency");
    if (n >= 40)
      test_done();
  endtask : run

  task automatic psr(input logic [31:0] v);
    run(mk(OP_WRITE_PSR, 1'b0, v, 32'h0, 32'h0), 0);
    check({rvalid, rwr, flags, q}, {2'b10, v[31:27]}, "flag write");
  endtask : psr

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_add;
    cdp_req_t r;
    r = mk(OP_ADD, 1'b0, 32'h5, 32'h7, 32'h0);
    run(r, 0);
    check(res_lo, 32'hc, "add register");
    r.use_imm = 1'b1;
    r.imm = 32'h64;
    run(r, 0);
    check(res_lo, 32'h69, "add immediate");
    run(mk(OP_ADD, 1'b1, 32'hffff_ffff, 32'h1, 32'h0), 0);
    check({res_lo, flags}, {32'h0, 4'h6}, "add carry out");
    run(mk(OP_ADD_CARRY, 1'b1, 32'h1, 32'h2, 32'h0), 0);
    check({res_lo, flags}, {32'h4, 4'h0}, "add with carry");
    run(mk(OP_SUB_CARRY, 1'b1, 32'h5, 32'h3, 32'h0), 0);
    check({res_lo, flags}, {32'h1, 4'h2}, "subtract with borrow");
    run(mk(OP_ADD_CARRY, 1'b1, 32'h7fff_ffff, 32'h0, 32'h0), 0);
    check({res_lo, flags}, {32'h8000_0000, 4'h9}, "carry into overflow");
  endtask : t_add

  // every condition code against four flag patterns, flag-setting move
  task automatic t_cond;
    logic [3:0] pat [4] = '{4'h6, 4'h9, 4'h8, 4'h1};
    cdp_req_t   r;
    logic       p;
    foreach (pat[i]) begin
      for (int c = 0; c < 16; c++) begin
        psr({pat[i], 28'h0});
        r = mk(OP_MOVE, 1'b1, 32'h0, 32'(c + 1), 32'h0);
        r.cond = c[3:0];
        p = cpass(c[3:0], pat[i]);
        run(r, 0);
        check({rwr, flags}, {p, p ? {2'b00, pat[i][1:0]} : pat[i]}, "condition gate");
      end
    end
  endtask : t_cond

  task automatic long_chk(input cdp_op_t op, input logic [31:0] a, b, input logic [63:0] acc, exp);
    cdp_req_t r;
    r = mk(op, 1'b1, a, b, 32'h0);
    r.acc_lo = acc[31:0];
    r.acc_hi = acc[63:32];
    run(r, 0);
    check({res_hi, res_lo}, exp, "long product");
    check({rwr, rwr_hi, flags}, {2'b11, 4'h5}, "long commit and flags");
  endtask : long_chk

  // flag-setting form requested on purpose: the accumulate, subtract and long multiplies must ignore it
  task automatic t_mul;
    logic [31:0] a, b, e;
    logic [63:0] acc, w;
    a = 32'hffff_fffd;
    b = 32'h7fff_ffff;
    acc = 64'h0000_0001_ffff_ffff;
    psr(32'h5000_0000);
    e = a * b + 32'h7;
    run(mk(OP_MUL_ACC, 1'b1, a, b, 32'h7), 0);
    check({res_lo, flags}, {e, 4'h5}, "multiply accumulate");
    e = 32'h7 - a * b;
    run(mk(OP_MUL_SUBTRACT, 1'b1, a, b, 32'h7), 0);
    check({res_lo, flags}, {e, 4'h5}, "multiply subtract");
    w = $signed(a) * $signed(b);
    long_chk(OP_SLONG_MUL, a, b, 64'h0, w);
    w = w + acc;
    long_chk(OP_SLONG_ACC, a, b, acc, w);
    w = {32'h0, a} * {32'h0, b};
    long_chk(OP_ULONG_MUL, a, b, 64'h0, w);
    w = {32'h0, a} * {32'h0, a} + acc;
    long_chk(OP_ULONG_ACC, a, a, acc, w);
  endtask : t_mul

  // rows: op, result, flags; source f0f0_1234, second 0ff0_0006, C and V start clear
  task automatic t_logic;
    logic [40:0] tab [7] = '{
      {OP_SUB, 32'he100_122e, 4'ha},    {OP_AND, 32'h00f0_0004, 4'h0},
      {OP_ORR, 32'hfff0_1236, 4'h8},    {OP_EOR, 32'hff00_1232, 4'h8},
      {OP_BITCLR, 32'hf000_1230, 4'h8}, {OP_MOVE_NOT, 32'hf00f_fff9, 4'h8},
      {OP_MUL, 32'hc260_6d38, 4'h8}};
    foreach (tab[i]) begin
      psr(32'h0);
      run(mk(cdp_op_t'(tab[i][40:36]), 1'b1, 32'hf0f0_1234, 32'h0ff0_0006, 32'h0), 0);
      check({rwr, res_lo, flags}, {1'b1, tab[i][35:0]}, "logic and subtract");
    end
  endtask : t_logic

  task automatic t_bytes;
    logic [31:0] v [2] = '{32'h1283_a4c5, 32'h0000_807f};
    foreach (v[i]) begin
      run(mk(OP_BSWAP_WORD, 1'b0, v[i], 32'h0, 32'h0), 0);
      check(res_lo, {v[i][7:0], v[i][15:8], v[i][23:16], v[i][31:24]}, "word reverse");
      run(mk(OP_BSWAP_HALVES, 1'b0, v[i], 32'h0, 32'h0), 0);
      check(res_lo, {v[i][23:16], v[i][31:24], v[i][7:0], v[i][15:8]}, "half swap");
      run(mk(OP_BSWAP_LOSEXT, 1'b0, v[i], 32'h0, 32'h0), 0);
      check(res_lo, {{16{v[i][7]}}, v[i][7:0], v[i][15:8]}, "low swap extend");
    end
  endtask : t_bytes

  // rows: op, lsb, width, expected, with source dead_beef and old 1234_5678
  task automatic t_field;
    logic [47:0] tab [8] = '{
      {OP_FIELD_INSERT, 5'd4, 6'd8, 32'h1234_5ef8}, {OP_FIELD_INSERT, 5'd16, 6'd16, 32'hbeef_5678},
      {OP_FIELD_CLEAR, 5'd0, 6'd32, 32'h0},         {OP_FIELD_CLEAR, 5'd9, 6'd1, 32'h1234_5478},
      {OP_FIELD_SEXT, 5'd28, 6'd4, 32'hffff_fffd},  {OP_FIELD_SEXT, 5'd0, 6'd8, 32'hffff_ffef},
      {OP_FIELD_ZEXT, 5'd8, 6'd12, 32'h0000_0dbe},  {OP_FIELD_ZEXT, 5'd0, 6'd32, 32'hdead_beef}};
    cdp_req_t r;
    foreach (tab[i]) begin
      r = mk(cdp_op_t'(tab[i][47:43]), 1'b0, 32'hdead_beef, 32'h0, 32'h0);
      r.dst = 32'h1234_5678;
      r.lsb = tab[i][42:38];
      r.width = tab[i][37:32];
      run(r, 0);
      check({rwr, res_lo}, {1'b1, tab[i][31:0]}, "bit field");
    end
  endtask : t_field

  // rows: op, n, shift, arithmetic, source, expected, saturation flag
  task automatic t_clamp;
    logic [81:0] tab [8] = '{
      {OP_CLAMP_S, 6'd8, 5'd0, 1'b0, 32'h100, 32'h7f, 1'b1},
      {OP_CLAMP_S, 6'd8, 5'd0, 1'b0, 32'hffff_fffb, 32'hffff_fffb, 1'b0},
      {OP_CLAMP_S, 6'd1, 5'd31, 1'b1, 32'h8000_0000, 32'hffff_ffff, 1'b0},
      {OP_CLAMP_S, 6'd32, 5'd0, 1'b0, 32'h8000_0000, 32'h8000_0000, 1'b0},
      {OP_CLAMP_U, 6'd8, 5'd0, 1'b0, 32'hffff_ffff, 32'h0, 1'b1},
      {OP_CLAMP_U, 6'd8, 5'd4, 1'b0, 32'h3, 32'h30, 1'b0},
      {OP_CLAMP_U, 6'd0, 5'd0, 1'b0, 32'h5, 32'h0, 1'b1},
      {OP_CLAMP_U, 6'd31, 5'd0, 1'b0, 32'h7fff_ffff, 32'h7fff_ffff, 1'b0}};
    cdp_req_t r;
    foreach (tab[i]) begin
      psr(32'h0);
      r = mk(cdp_op_t'(tab[i][81:77]), 1'b0, 32'h0, tab[i][64:33], 32'h0);
      r.sat_n = tab[i][76:71];
      r.shift = tab[i][70:66];
      r.asr = tab[i][65];
      run(r, 0);
      check({res_lo, q}, tab[i][32:0], "clamp");
    end
    // flag is sticky: a clamping op, then an in-range one leaves it set
    r.rm = 32'hffff_ffff;
    run(r, 0);
    check({res_lo, q}, {32'h0, 1'b1}, "clamp to zero");
    r.rm = 32'h1;
    run(r, 0);
    check({res_lo, q}, {32'h1, 1'b1}, "sticky saturation");
  endtask : t_clamp

  // rows: op, dividend, divisor, quotient
  task automatic t_div;
    logic [100:0] tab [4] = '{
      {OP_DIV_S, 32'hffff_fff9, 32'h2, 32'hffff_fffd}, {OP_DIV_S, 32'h7, 32'hffff_fffe, 32'hffff_fffd},
      {OP_DIV_U, 32'hffff_ffff, 32'h2, 32'h7fff_ffff}, {OP_DIV_U, 32'h5, 32'h0, 32'h0}};
    cdp_req_t r;
    psr(32'h9000_0000);
    foreach (tab[i]) begin
      run(mk(cdp_op_t'(tab[i][100:96]), 1'b1, tab[i][95:64], tab[i][63:32], 32'h0), 33);
      check({busy, rwr, flags, res_lo}, {2'b01, 4'h9, tab[i][31:0]}, "divide");
    end
    // failed condition answers at once and commits nothing
    r = mk(OP_DIV_U, 1'b0, 32'h9, 32'h3, 32'h0);
    r.cond = CC_EQ;
    run(r, 0);
    check({busy, rvalid, rwr, flags}, {3'b010, 4'h9}, "refused divide");
  endtask : t_div

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    srst = 1'b1;
    failures = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    #1;
    check({res_hi, res_lo}, 64'h0, "results at reset");
    check({busy, rvalid, rwr, rwr_hi, flags, q}, 64'h0, "strobes at reset");
    srst = 1'b0;
    @(posedge clk);
    #1;
    t_add();
    t_logic();
    t_cond();
    t_mul();
    t_bytes();
    t_field();
    t_clamp();
    t_div();
    test_done();
  end
endmodule : cdp_datapath_tb

// File: cdp_dec_model.sv
// stand-in for the decoder and register file, one operation at a time
`timescale 1ns/100ps
module cdp_dec_model
  import cdp_tb_pkg::*;
(
  // clock
  input  wire logic i_clk,
  // answer strobe from the datapath
  input  wire logic i_res_valid,
  // offered operation
  output cdp_req_t  o_req
);
  initial o_req = '0;

  ////////////////////////////////////////////////////////////////////////////
  // offer for one edge, then scramble released rn, rm, ra and imm so stale values of those never pass
  task automatic issue(input cdp_req_t r, output int n);
    // one idle edge first: valid never drops and rises in one time step
    @(posedge i_clk);
    #1;
    o_req = r;
    o_req.valid = 1'b1;
    @(posedge i_clk);
    #1;
    o_req.valid = 1'b0;
    o_req.rn = ~r.rn;
    o_req.rm = ~r.rm;
    o_req.ra = ~r.ra;
    o_req.imm = ~r.imm;
    n = 0;
    // bounded: a divide answers well inside 40 edges
    while (i_res_valid !== 1'b1 && n < 40) begin
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask : issue
endmodule : cdp_dec_model

// File: cdp_div_if.sv
// request and answer between datapath and iterative divider
`timescale 1ns/100ps
interface cdp_div_if;
  logic        start;
  logic        sgn;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic        done;
  logic [31:0] quotient;
  modport req (output start, sgn, dividend, divisor, input done, quotient);
  modport div (input start, sgn, dividend, divisor, output done, quotient);
endinterface : cdp_div_if

// File: cdp_divider.sv
// iterative restoring divider, one quotient bit per cycle
`timescale 1ns/100ps
module cdp_divider
  import cdp_pkg::*;
(
  // clock and reset
  input  wire logic I_CORE_CLK,
  input  wire logic I_SRST,
  // divider port
  cdp_div_if.div    dv
);

  typedef struct packed {
    logic        busy;
    logic [5:0]  cnt;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] dvs;
    logic        neg;
    logic        zero;
    logic        done;
    logic [31:0] q_out;
  } cdp_div_st_t;

  localparam cdp_div_st_t DIV_RST = '0;

  cdp_div_st_t st_r;
  cdp_div_st_t st_nxt;
  logic [32:0] trial;
  logic        qbit;
  logic [31:0] qnew;

  ////////////////////////////////////////////////////////////////////////
  // next state: load magnitudes, then shift-subtract
  always_comb begin
    st_nxt  = st_r;
    st_nxt.done = 1'b0;
    trial   = {st_r.rem, st_r.quo[31]};
    qbit    = (trial >= {1'b0, st_r.dvs});
    qnew    = {st_r.quo[30:0], qbit};
    if (dv.start && !st_r.busy) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = DIV_STEPS;
      st_nxt.rem  = '0;
      st_nxt.quo  = (dv.sgn && dv.dividend[31]) ? 32'(-dv.dividend) : dv.dividend;
      st_nxt.dvs  = (dv.sgn && dv.divisor[31]) ? 32'(-dv.divisor) : dv.divisor;
      st_nxt.neg  = dv.sgn && (dv.dividend[31] ^ dv.divisor[31]);
      st_nxt.zero = (dv.divisor == '0);
    end else if (st_r.busy) begin
      st_nxt.rem = qbit ? 32'(trial - {1'b0, st_r.dvs}) : trial[31:0];
      st_nxt.quo = qnew;
      st_nxt.cnt = st_r.cnt - 6'h01;
      if (st_r.cnt == 6'h01) begin
        // truncation toward zero: negate the magnitude quotient; x/0 gives 0
        st_nxt.busy  = 1'b0;
        st_nxt.done  = 1'b1;
        st_nxt.q_out = st_r.zero ? '0 : (st_r.neg ? 32'(-qnew) : qnew);
      end
    end
  end

  // state register
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      st_r <= DIV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dv.done     = st_r.done;
  assign dv.quotient = st_r.q_out;

endmodule : cdp_divider

// File: cdp_pkg.sv
// shared constants and types for the data-processing datapath
package cdp_pkg;

  localparam int          XLEN        = 32;
  localparam logic [5:0]  DIV_STEPS   = 6'h20;
  localparam logic [3:0]  FLAGS_RST   = 4'h0;
  localparam logic        QFLAG_RST   = 1'h0;
  localparam int          FLG_N       = 3;
  localparam int          FLG_Z       = 2;
  localparam int          FLG_C       = 1;
  localparam int          FLG_V       = 0;
  localparam int          PSR_NZCV_LO = 28;
  localparam int          PSR_Q_BIT   = 27;

  // operation codes presented by the decoder
  typedef enum logic [4:0] {
    OP_ADD          = 5'b00000,
    OP_ADD_CARRY    = 5'b00001,
    OP_SUB          = 5'b00010,
    OP_SUB_CARRY    = 5'b00011,
    OP_AND          = 5'b00100,
    OP_ORR          = 5'b00101,
    OP_EOR          = 5'b00110,
    OP_BITCLR       = 5'b00111,
    OP_MOVE         = 5'b01000,
    OP_MOVE_NOT     = 5'b01001,
    OP_MUL          = 5'b01010,
    OP_MUL_ACC      = 5'b01011,
    OP_MUL_SUBTRACT = 5'b01100,
    OP_SLONG_MUL    = 5'b01101,
    OP_ULONG_MUL    = 5'b01110,
    OP_SLONG_ACC    = 5'b01111,
    OP_ULONG_ACC    = 5'b10000,
    OP_BSWAP_WORD   = 5'b10001,
    OP_BSWAP_HALVES = 5'b10010,
    OP_BSWAP_LOSEXT = 5'b10011,
    OP_FIELD_INSERT = 5'b10100,
    OP_FIELD_CLEAR  = 5'b10101,
    OP_FIELD_SEXT   = 5'b10110,
    OP_FIELD_ZEXT   = 5'b10111,
    OP_WRITE_PSR    = 5'b11000,
    OP_CLAMP_S      = 5'b11001,
    OP_CLAMP_U      = 5'b11010,
    OP_DIV_S        = 5'b11011,
    OP_DIV_U        = 5'b11100
  } cdp_op_t;

  // condition codes
  typedef enum logic [3:0] {
    CC_EQ = 4'b0000, CC_NE = 4'b0001, CC_CS = 4'b0010, CC_CC = 4'b0011,
    CC_MI = 4'b0100, CC_PL = 4'b0101, CC_VS = 4'b0110, CC_VC = 4'b0111,
    CC_HI = 4'b1000, CC_LS = 4'b1001, CC_GE = 4'b1010, CC_LT = 4'b1011,
    CC_GT = 4'b1100, CC_LE = 4'b1101, CC_AL = 4'b1110, CC_NV = 4'b1111
  } cdp_cond_t;

endpackage : cdp_pkg

// File: cdp_tb_pkg.sv
// request bundle the bench offers to the datapath
package cdp_tb_pkg;

  // one decoded operation with all its operands
  typedef struct packed {
    logic        valid;
    logic [4:0]  op;
    logic [3:0]  cond;
    logic        sf;
    logic        use_imm;
    logic [31:0] imm;
    logic [31:0] rn;
    logic [31:0] rm;
    logic [31:0] ra;
    logic [31:0] dst;
    logic [31:0] acc_lo;
    logic [31:0] acc_hi;
    logic [4:0]  lsb;
    logic [5:0]  width;
    logic [5:0]  sat_n;
    logic [4:0]  shift;
    logic        asr;
  } cdp_req_t;

endpackage : cdp_tb_pkg
